// file: hdl/sleep_pin_pkg.sv
// shared constants and types for the sleep pin-state controller
package sleep_pin_pkg;
    localparam int NUM_PINS = 128;
    localparam int NUM_WORDS = 4;
    localparam int ADDR_W = 8;
    // register byte offsets
    localparam logic [7:0] OFF_SLEEP_STATUS = 8'h00;
    localparam logic [7:0] OFF_POWER_CONFIG = 8'h04;
    localparam logic [7:0] OFF_USIM_PIN_CTRL = 8'h08;
    localparam logic [7:0] OFF_OSC_CONFIG = 8'h0C;
    localparam logic [7:0] OFF_SLEEP_VALUE0 = 8'h10;
    // field positions
    localparam int BIT_READ_DISABLE_HOLD = 0;
    localparam int BIT_PERIPHERAL_HOLD = 1;
    localparam int BIT_IN_SLEEP = 2;
    localparam int BIT_IN_DEEP = 3;
    localparam int BIT_STATIC_MEM_FLOAT = 0;
    localparam int BIT_CARD_PINS_FLOAT = 1;
    localparam int BIT_OS_TIMER_SLEEP = 2;
    localparam int BIT_FORCE_SIM_A = 0;
    localparam int BIT_FORCE_SIM_B = 1;
    localparam int BIT_PROC_CLK_EN = 0;
    localparam int BIT_TIMER_CLK_EN = 1;
    // special pins
    localparam int PIN_PROC_CLK = 9;
    localparam int PIN_TIMER_CLK = 10;
    localparam int PIN_SIM_A = 114;
    localparam int PIN_SIM_B = 115;
    // per-pin attributes (board dependent, plain defaults)
    localparam logic [127:0] PULL_UP_MASK = 128'h0000_0000_0000_0000_0000_0000_0000_FF00;
    localparam logic [127:0] PULL_DOWN_MASK = 128'h0000_0000_0000_0000_0000_0000_00FF_0000;
    localparam logic [127:0] STATIC_MEM_MASK = 128'h0000_0000_0000_0000_0000_0000_0F00_0000;
    localparam logic [127:0] CARD_MASK = 128'h0000_0000_0000_0000_0000_000F_0000_0000;
    localparam logic [127:0] OST_STOP_MASK = 128'h0000_0000_0000_0000_0000_00F0_0000_0000;
    localparam int NUM_MEM_CTL = 4;
    // reset values
    localparam logic [31:0] SLEEP_VALUE_RST = 32'h0000_0000;
    // power sequencing times
    localparam int CLK_PERIOD_NS = 25;
    localparam int SYS_TO_PWR_NS = 1000;
    localparam int PWR_TO_REL_NS = 2000;
    localparam int SYS_TO_PWR_CYC = (SYS_TO_PWR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PWR_TO_REL_CYC = (PWR_TO_REL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [1:0] {MODE_RUN, MODE_STANDBY, MODE_SLEEP, MODE_DEEP} power_mode_t;
    typedef enum logic [1:0] {SEQ_SYS, SEQ_PWR, SEQ_RUN} seq_state_t;
endpackage

// file: hdl/apb_reg_port.sv
// apb slave front end: strobes and unmapped-address error
`timescale 1ns/1ps
module apb_reg_port
    import sleep_pin_pkg::*;
(
    input wire logic psel, // select
    input wire logic penable, // access phase
    input wire logic pwrite, // write direction
    input wire logic [ADDR_W-1:0] paddr, // byte address
    output logic pready, // always ready
    output logic pslverr, // unmapped access
    output logic wrStrobe, // mapped write taking effect
    output logic accessHit // address is mapped
);
    function automatic logic isMapped(input logic [ADDR_W-1:0] a);
        isMapped = (a[1:0] == 2'h0) && (a <= OFF_SLEEP_VALUE0 + 8'h0C);
    endfunction

    // zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign accessHit = isMapped(paddr);
    assign pslverr = psel && penable && !isMapped(paddr);
    assign wrStrobe = psel && penable && pwrite && isMapped(paddr);
endmodule // apb_reg_port

// file: hdl/pad_state_cell.sv
// per-pin pad state decision
`timescale 1ns/1ps
module pad_state_cell (
    input wire logic readHold, // read-disable hold
    input wire logic periphHold, // peripheral hold
    input wire logic sleeping, // standby or sleep
    input wire logic deepSleep, // deep sleep
    input wire logic heldDir, // direction caught at sleep entry
    input wire logic heldVal, // sleep value caught at sleep entry
    input wire logic floatSel, // float bit applies to this pin
    input wire logic ostStop, // pin stops while os timer runs in sleep
    input wire logic defPullUp, // default pull-up
    input wire logic defPullDown, // default pull-down
    input wire logic pmOverride, // power manager owns pin
    input wire logic pmOut, // power manager level
    input wire logic pmOe, // power manager enable
    input wire logic funcOut, // functional level
    input wire logic funcOe, // functional enable
    output logic padOut, // pad level
    output logic padOe, // pad enable
    output logic padInEn, // input buffer enable
    output logic padPullUp, // pull-up enable
    output logic padPullDown // pull-down enable
);
    always_comb begin
        padOut = funcOut;
        padOe = funcOe;
        padInEn = !readHold;
        padPullUp = readHold && defPullUp;
        padPullDown = readHold && defPullDown;
        if (pmOverride) begin
            // sleep values and read hold do not apply here
            padOut = pmOut;
            padOe = pmOe;
            padInEn = 1'b1;
            padPullUp = 1'b0;
            padPullDown = 1'b0;
        end else if (deepSleep) begin
            padOe = 1'b0;
            padInEn = 1'b0;
        end else if (sleeping) begin
            padOut = heldVal;
            padOe = heldDir && !floatSel && !ostStop;
            padInEn = 1'b0;
        end else if (periphHold && heldDir) begin
            padOut = heldVal;
            padOe = 1'b1;
        end else if (readHold) begin
            padOe = 1'b0;
        end
    end
endmodule // pad_state_cell

// file: hdl/sleep_pin_state_control.sv
// pad-state control across reset, sleep, deep sleep and wake
// Summary of operation
// - reset and deep sleep: inputs, buffers off
// - input buffers off until read hold cleared
// - default pull per pin while read hold
// - oscillator connections pass through untouched
// - sleeping input-direction pins are not driven
// - sleeping output pins drive sleep value
// - outputs keep sleep level until peripheral hold cleared
// - peripheral hold cleared by writing one
// - wake inputs unusable until read hold cleared
// - static-memory pins float when bit set
// - card pins float when bit set
// - power manager override ignores sleep value, hold
// - pulls off under power manager override
// - non-gpio memory pins float by bit only
// - power enable after system enable, before release
// - usim force drives enable on pins 114/115
// - clock outputs override pins 9 and 10
// - some pins stop while os timer sleeps
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module sleep_pin_state_control
    import sleep_pin_pkg::*;
(
    input wire logic core_clk, // 40 MHz clock
    input wire logic reset, // async reset, active high
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb write
    input wire logic [ADDR_W-1:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic [1:0] powerMode, // power mode from power manager
    input wire logic resetPinActive, // external reset pin asserted
    input wire logic [NUM_PINS-1:0] gpioDir, // gpio direction, 1 = output
    input wire logic [NUM_PINS-1:0] funcOut, // alternate-function level
    input wire logic [NUM_PINS-1:0] funcOe, // alternate-function enable
    input wire logic [NUM_PINS-1:0] pmOverride, // power manager owns pin
    input wire logic [NUM_PINS-1:0] pmOut, // power manager level
    input wire logic [NUM_PINS-1:0] pmOe, // power manager enable
    input wire logic [NUM_PINS-1:0] padIn, // pad input levels
    output logic [NUM_PINS-1:0] gpioIn, // gated pad inputs
    output logic [NUM_PINS-1:0] padOut, // pad levels
    output logic [NUM_PINS-1:0] padOe, // pad enables
    output logic [NUM_PINS-1:0] padInEn, // input buffer enables
    output logic [NUM_PINS-1:0] padPullUp, // pull-up enables
    output logic [NUM_PINS-1:0] padPullDown, // pull-down enables
    input wire logic [NUM_MEM_CTL-1:0] memCtlOut, // non-gpio memory control level
    input wire logic [NUM_MEM_CTL-1:0] memCtlOe, // non-gpio memory control enable
    output logic [NUM_MEM_CTL-1:0] memCtlPadOut, // memory control pad level
    output logic [NUM_MEM_CTL-1:0] memCtlPadOe, // memory control pad enable
    input wire logic usimEnable, // usim enable signal
    input wire logic procClk, // processor clock to bring out
    input wire logic timerClk, // timer clock to bring out
    input wire logic oscIn, // oscillator connection in
    output logic oscOut, // oscillator connection out
    output logic systemPowerEnable, // system power enable
    output logic corePowerEnable, // core power enable
    output logic internalReset // internal reset, active high
);
    typedef struct packed {
        logic readHold;
        logic periphHold;
        logic memFloat;
        logic cardFloat;
        logic ostSleep;
        logic simA;
        logic simB;
        logic procClkEn;
        logic timerClkEn;
        logic [NUM_WORDS-1:0][31:0] sleepVal;
        logic [NUM_PINS-1:0] heldDir;
        logic [NUM_PINS-1:0] heldVal;
        logic [1:0] prevMode;
        seq_state_t seq;
        logic [7:0] seqCnt;
        logic sysEn;
        logic pwrEn;
        logic intRst;
        logic [NUM_PINS-1:0] out;
        logic [NUM_PINS-1:0] oe;
        logic [NUM_PINS-1:0] inEn;
        logic [NUM_PINS-1:0] pu;
        logic [NUM_PINS-1:0] pd;
        logic [NUM_MEM_CTL-1:0] memOut;
        logic [NUM_MEM_CTL-1:0] memOe;
    } state_t;

    localparam logic [7:0] SYS_TO_PWR_CNT = 8'(SYS_TO_PWR_CYC);
    localparam logic [7:0] PWR_TO_REL_CNT = 8'(PWR_TO_REL_CYC);

    state_t state_r;
    state_t state_nxt;
    logic wrStrobe;
    logic accessHit;
    logic sleeping;
    logic deepSleep;
    logic enterLowPower;
    logic [NUM_PINS-1:0] muxOut;
    logic [NUM_PINS-1:0] muxOe;
    logic [NUM_PINS-1:0] cellOut;
    logic [NUM_PINS-1:0] cellOe;
    logic [NUM_PINS-1:0] cellInEn;
    logic [NUM_PINS-1:0] cellPu;
    logic [NUM_PINS-1:0] cellPd;
    logic [NUM_PINS-1:0] floatMask;

    function automatic logic regSel(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        regSel = (a == off);
    endfunction

    apb_reg_port u_apb (
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pready(pready),
        .pslverr(pslverr),
        .wrStrobe(wrStrobe),
        .accessHit(accessHit)
    );

    assign sleeping = (powerMode == MODE_SLEEP) || (powerMode == MODE_STANDBY);
    assign deepSleep = (powerMode == MODE_DEEP);
    assign enterLowPower = (powerMode != MODE_RUN) && (state_r.prevMode == MODE_RUN);

    // crystal path never passes through pad state logic
    assign oscOut = oscIn;

    // function overrides ahead of the sleep logic; clock outputs win over usim
    always_comb begin
        muxOut = funcOut;
        muxOe = funcOe;
        if (state_r.simA || state_r.simB) begin
            muxOut[PIN_SIM_A] = usimEnable;
            muxOe[PIN_SIM_A] = 1'b1;
            muxOut[PIN_SIM_B] = usimEnable;
            muxOe[PIN_SIM_B] = 1'b1;
        end
        if (state_r.procClkEn || state_r.timerClkEn) begin
            muxOut[PIN_PROC_CLK] = procClk;
            muxOe[PIN_PROC_CLK] = 1'b1;
            muxOut[PIN_TIMER_CLK] = timerClk;
            muxOe[PIN_TIMER_CLK] = 1'b1;
        end
    end

    // pins left out of both masks are software's job to float before sleep
    assign floatMask = (state_r.memFloat ? STATIC_MEM_MASK : '0)
        | (state_r.cardFloat ? CARD_MASK : '0);

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_pad
            pad_state_cell u_cell (
                .readHold(state_r.readHold),
                .periphHold(state_r.periphHold),
                .sleeping(sleeping),
                .deepSleep(deepSleep),
                .heldDir(state_r.heldDir[gi]),
                .heldVal(state_r.heldVal[gi]),
                .floatSel(floatMask[gi]),
                .ostStop(state_r.ostSleep && OST_STOP_MASK[gi]),
                .defPullUp(PULL_UP_MASK[gi]),
                .defPullDown(PULL_DOWN_MASK[gi]),
                .pmOverride(pmOverride[gi]),
                .pmOut(pmOut[gi]),
                .pmOe(pmOe[gi]),
                .funcOut(muxOut[gi]),
                .funcOe(muxOe[gi]),
                .padOut(cellOut[gi]),
                .padOe(cellOe[gi]),
                .padInEn(cellInEn[gi]),
                .padPullUp(cellPu[gi]),
                .padPullDown(cellPd[gi])
            );
        end
    endgenerate

    always_comb begin
        state_nxt = state_r;
        state_nxt.prevMode = powerMode;
        // register writes
        if (wrStrobe) begin
            if (regSel(paddr, OFF_SLEEP_STATUS)) begin
                if (pwdata[BIT_READ_DISABLE_HOLD]) begin
                    state_nxt.readHold = 1'b0;
                end
                if (pwdata[BIT_PERIPHERAL_HOLD]) begin
                    state_nxt.periphHold = 1'b0;
                end
            end
            if (regSel(paddr, OFF_POWER_CONFIG)) begin
                state_nxt.memFloat = pwdata[BIT_STATIC_MEM_FLOAT];
                state_nxt.cardFloat = pwdata[BIT_CARD_PINS_FLOAT];
                state_nxt.ostSleep = pwdata[BIT_OS_TIMER_SLEEP];
            end
            if (regSel(paddr, OFF_USIM_PIN_CTRL)) begin
                state_nxt.simA = pwdata[BIT_FORCE_SIM_A];
                state_nxt.simB = pwdata[BIT_FORCE_SIM_B];
            end
            if (regSel(paddr, OFF_OSC_CONFIG)) begin
                state_nxt.procClkEn = pwdata[BIT_PROC_CLK_EN];
                state_nxt.timerClkEn = pwdata[BIT_TIMER_CLK_EN];
            end
            for (int w = 0; w < NUM_WORDS; w++) begin
                if (regSel(paddr, OFF_SLEEP_VALUE0 + 8'(4 * w))) begin
                    state_nxt.sleepVal[w] = pwdata;
                end
            end
        end
        // hardware set after the write so a same-cycle set wins over the clear
        if (enterLowPower || resetPinActive) begin
            state_nxt.readHold = 1'b1;
            state_nxt.periphHold = 1'b1;
        end
        if (enterLowPower) begin
            state_nxt.heldDir = gpioDir;
            state_nxt.heldVal = state_r.sleepVal;
        end
        if (resetPinActive) begin
            state_nxt.heldDir = '0;
        end
        // power-up sequence
        unique case (state_r.seq)
            SEQ_SYS: begin
                // system enable only rises one edge after release, so count the full span here
                if (state_r.seqCnt == SYS_TO_PWR_CNT) begin
                    state_nxt.seq = SEQ_PWR;
                    state_nxt.seqCnt = 8'h00;
                end else begin
                    state_nxt.seqCnt = state_r.seqCnt + 8'h01;
                end
            end
            SEQ_PWR: begin
                if (state_r.seqCnt == PWR_TO_REL_CNT - 8'h01) begin
                    state_nxt.seq = SEQ_RUN;
                    state_nxt.seqCnt = 8'h00;
                end else begin
                    state_nxt.seqCnt = state_r.seqCnt + 8'h01;
                end
            end
            SEQ_RUN: begin
                state_nxt.seqCnt = 8'h00;
            end
            default: begin
                state_nxt.seq = SEQ_SYS;
                state_nxt.seqCnt = 8'h00;
            end
        endcase
        if (resetPinActive) begin
            state_nxt.seq = SEQ_SYS;
            state_nxt.seqCnt = 8'h00;
        end
        state_nxt.sysEn = 1'b1;
        state_nxt.pwrEn = (state_nxt.seq != SEQ_SYS);
        state_nxt.intRst = (state_nxt.seq != SEQ_RUN);
        // pads
        state_nxt.out = cellOut;
        state_nxt.oe = cellOe;
        state_nxt.inEn = cellInEn;
        state_nxt.pu = cellPu;
        state_nxt.pd = cellPd;
        state_nxt.memOut = memCtlOut;
        state_nxt.memOe = (sleeping || deepSleep) && state_r.memFloat ? '0 : memCtlOe;
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_r.readHold <= 1'b1;
            state_r.periphHold <= 1'b1;
            state_r.memFloat <= 1'b0;
            state_r.cardFloat <= 1'b0;
            state_r.ostSleep <= 1'b0;
            state_r.simA <= 1'b0;
            state_r.simB <= 1'b0;
            state_r.procClkEn <= 1'b0;
            state_r.timerClkEn <= 1'b0;
            state_r.sleepVal <= {NUM_WORDS{SLEEP_VALUE_RST}};
            state_r.heldDir <= '0;
            state_r.heldVal <= '0;
            state_r.prevMode <= MODE_RUN;
            state_r.seq <= SEQ_SYS;
            state_r.seqCnt <= 8'h00;
            state_r.sysEn <= 1'b0;
            state_r.pwrEn <= 1'b0;
            state_r.intRst <= 1'b1;
            state_r.out <= '0;
            state_r.oe <= '0;
            state_r.inEn <= '0;
            state_r.pu <= PULL_UP_MASK;
            state_r.pd <= PULL_DOWN_MASK;
            state_r.memOut <= '0;
            state_r.memOe <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // register read mux; unmapped reads return zero
    always_comb begin
        prdata = 32'h0000_0000;
        if (accessHit) begin
            if (regSel(paddr, OFF_SLEEP_STATUS)) begin
                prdata[BIT_READ_DISABLE_HOLD] = state_r.readHold;
                prdata[BIT_PERIPHERAL_HOLD] = state_r.periphHold;
                prdata[BIT_IN_SLEEP] = sleeping;
                prdata[BIT_IN_DEEP] = deepSleep;
            end
            if (regSel(paddr, OFF_POWER_CONFIG)) begin
                prdata[BIT_STATIC_MEM_FLOAT] = state_r.memFloat;
                prdata[BIT_CARD_PINS_FLOAT] = state_r.cardFloat;
                prdata[BIT_OS_TIMER_SLEEP] = state_r.ostSleep;
            end
            if (regSel(paddr, OFF_USIM_PIN_CTRL)) begin
                prdata[BIT_FORCE_SIM_A] = state_r.simA;
                prdata[BIT_FORCE_SIM_B] = state_r.simB;
            end
            if (regSel(paddr, OFF_OSC_CONFIG)) begin
                prdata[BIT_PROC_CLK_EN] = state_r.procClkEn;
                prdata[BIT_TIMER_CLK_EN] = state_r.timerClkEn;
            end
            for (int w = 0; w < NUM_WORDS; w++) begin
                if (regSel(paddr, OFF_SLEEP_VALUE0 + 8'(4 * w))) begin
                    prdata = state_r.sleepVal[w];
                end
            end
        end
    end

    // disabled input buffers read as zero, so no floating level reaches the core
    assign gpioIn = padIn & state_r.inEn;
    assign padOut = state_r.out;
    assign padOe = state_r.oe;
    assign padInEn = state_r.inEn;
    assign padPullUp = state_r.pu;
    assign padPullDown = state_r.pd;
    assign memCtlPadOut = state_r.memOut;
    assign memCtlPadOe = state_r.memOe;
    assign systemPowerEnable = state_r.sysEn;
    assign corePowerEnable = state_r.pwrEn;
    assign internalReset = state_r.intRst;
endmodule // sleep_pin_state_control

// file: dv/sleep_pin_state_control_props.sv
// assertion checker for the sleep pin-state controller
`timescale 1ns/1ps
module sleep_pin_state_control_props
    import sleep_pin_pkg::*;
(
    input wire logic core_clk, // clock
    input wire logic reset, // async reset
    input wire logic [1:0] powerMode, // power mode
    input wire logic [NUM_PINS-1:0] gpioDir, // direction
    input wire logic [NUM_PINS-1:0] pmOverride, // power manager takeover
    input wire logic [NUM_PINS-1:0] padOe, // pad enables
    input wire logic [NUM_PINS-1:0] padInEn, // buffer enables
    input wire logic [NUM_PINS-1:0] padPullUp, // pull-ups
    input wire logic [NUM_PINS-1:0] padPullDown, // pull-downs
    input wire logic oscIn, // oscillator in
    input wire logic oscOut, // oscillator out
    input wire logic systemPowerEnable, // system enable
    input wire logic corePowerEnable, // core enable
    input wire logic internalReset // internal reset
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    chk_osc_pass: assert property (oscOut == oscIn)
        else $error("oscillator path altered");
    chk_pwr_order: assert property (corePowerEnable |-> systemPowerEnable)
        else $error("core power before system power");
    chk_rel_order: assert property (!internalReset |-> corePowerEnable)
        else $error("reset released without core power");
    chk_pwr_delay: assert property ($rose(systemPowerEnable) |-> ##40 $rose(corePowerEnable))
        else $error("core power rise not 40 cycles after system power");
    chk_rel_delay: assert property ($rose(corePowerEnable) |-> ##80 $fell(internalReset))
        else $error("internal reset release not 80 cycles after core power");
    chk_deep_buffers: assert property ((powerMode == 2'd3) [*2] |=> (padInEn & ~$past(pmOverride)) == '0)
        else $error("input buffer on in deep sleep");
    chk_pm_pulls: assert property (1'b1 |=> ((padPullUp | padPullDown) & $past(pmOverride)) == '0)
        else $error("pull left on under power manager");
    // pin 40 carries no special attribute, so plain input behaviour applies
    chk_sleep_input: assert property ((powerMode == 2'd0)
        ##1 (powerMode == 2'd2 && !gpioDir[40] && !pmOverride[40])
        ##1 (powerMode == 2'd2 && !pmOverride[40]) |=> !padOe[40])
        else $error("sleeping input pin driven");
endmodule // sleep_pin_state_control_props

bind sleep_pin_state_control sleep_pin_state_control_props chk (.core_clk, .reset, .powerMode,
    .gpioDir, .pmOverride, .padOe, .padInEn, .padPullUp, .padPullDown, .oscIn, .oscOut,
    .systemPowerEnable, .corePowerEnable, .internalReset);

// file: dv/sleep_pin_state_control_tb.sv
// self-checking bench for the sleep pin-state controller
`timescale 1ns/1ps
module sleep_pin_state_control_tb
    import sleep_pin_pkg::*;
;
    logic core_clk, reset, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] powerMode;
    logic resetPinActive, usimEnable, procClk, timerClk, oscIn, oscOut;
    logic systemPowerEnable, corePowerEnable, internalReset;
    logic [NUM_PINS-1:0] gpioDir, funcOut, funcOe, pmOverride, pmOut, pmOe, padIn;
    logic [NUM_PINS-1:0] gpioIn, padOut, padOe, padInEn, padPullUp, padPullDown;
    logic [NUM_MEM_CTL-1:0] memCtlOut, memCtlOe, memCtlPadOut, memCtlPadOe;
    int nErrors, testsRun;
    sleep_pin_state_control dut (.core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .powerMode, .resetPinActive, .gpioDir, .funcOut, .funcOe,
        .pmOverride, .pmOut, .pmOe, .padIn, .gpioIn, .padOut, .padOe, .padInEn, .padPullUp,
        .padPullDown, .memCtlOut, .memCtlOe, .memCtlPadOut, .memCtlPadOe, .usimEnable, .procClk,
        .timerClk, .oscIn, .oscOut, .systemPowerEnable, .corePowerEnable, .internalReset);
    task automatic chk(input string n, input logic [127:0] s, input logic [127:0] e);
        testsRun++;
        if (s !== e) begin
            nErrors++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    // one apb transfer; read data and error taken at the completing edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", testsRun, nErrors);
        if (nErrors == 0 && testsRun > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    initial begin
        #200000;
        nErrors++;
        conclude();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, powerMode, resetPinActive} = '0;
        {usimEnable, procClk, timerClk, gpioDir, funcOut, pmOverride, pmOut, pmOe} = '0;
        {reset, oscIn, funcOe, padIn, memCtlOut, memCtlOe} = {2'b11, {256{1'b1}}, 8'hAF};
        {nErrors, testsRun} = '0;
        tick(1);
        #1;
        chk("oscOut", oscOut, 1'b1);
        chk("padOe", padOe, '0);
        chk("padInEn", padInEn, '0);
        chk("pullUp", padPullUp, PULL_UP_MASK);
        chk("pullDown", padPullDown, PULL_DOWN_MASK);
        chk("gpioIn", gpioIn, '0);
        tick(1);
        reset <= 1'b0;
        tick(125);
        #1;
        chk("internalReset", internalReset, 1'b0);
        apb(0, OFF_SLEEP_STATUS, 0);
        chk("status", rd, 32'h3);
        apb(1, OFF_SLEEP_STATUS, 0);
        apb(0, OFF_SLEEP_STATUS, 0);
        chk("status", rd, 32'h3);
        apb(1, OFF_SLEEP_STATUS, 32'h1);
        tick(2);
        #1;
        chk("gpioIn", gpioIn, padIn);
        apb(0, 8'h40, 0);
        chk("slverr", err, 1'b1);
        $display("reset test done");
        apb(1, OFF_SLEEP_VALUE0, 32'h0000_00A5);
        apb(1, OFF_POWER_CONFIG, 32'h7);
        gpioDir <= 128'h0000_0000_0000_0000_0000_00FF_0F00_00FF;
        powerMode <= 2'd2;
        tick(3);
        #1;
        chk("sleepOe", padOe, 128'h00FF);
        chk("sleepOut", padOut[7:0], 8'hA5);
        chk("memCtl", {memCtlPadOe, memCtlPadOut}, 8'h0A);
        apb(0, OFF_SLEEP_STATUS, 0);
        chk("status", rd, 32'h7);
        funcOut <= '1;
        powerMode <= 2'd0;
        tick(3);
        #1;
        chk("wakeOut", {padOe[7:0], padOut[7:0]}, 16'hFFA5);
        chk("wakeInEn", padInEn & ~gpioDir, '0);
        apb(1, OFF_SLEEP_STATUS, 32'h2);
        tick(2);
        #1;
        chk("freedOut", padOut[7:0], 8'hFF);
        apb(1, OFF_SLEEP_STATUS, 32'h1);
        tick(2);
        #1;
        chk("inEn", padInEn & ~gpioDir, ~gpioDir);
        $display("sleep test done");
        tick(1);
        {procClk, usimEnable} <= 2'b11;
        // timer bit alone must still bring out both clocks
        apb(1, OFF_OSC_CONFIG, 32'h2);
        apb(1, OFF_USIM_PIN_CTRL, 32'h1);
        tick(2);
        #1;
        chk("clkPins", {padOe[10:9], padOut[10:9]}, 4'b1101);
        chk("simPins", {padOe[115:114], padOut[115:114]}, 4'hF);
        $display("force test done");
        tick(1);
        resetPinActive <= 1'b1;
        tick(1);
        resetPinActive <= 1'b0;
        tick(2);
        #1;
        chk("pinRst", {systemPowerEnable, corePowerEnable, internalReset}, 3'b101);
        apb(0, OFF_SLEEP_STATUS, 0);
        chk("status", rd, 32'h3);
        tick(125);
        #1;
        chk("pinRstDone", internalReset, 1'b0);
        $display("pin reset test done");
        apb(1, OFF_OSC_CONFIG, 0);
        apb(1, OFF_USIM_PIN_CTRL, 0);
        {pmOverride, pmOe, pmOut} <= {3{128'h0100}};
        powerMode <= 2'd3;
        tick(3);
        #1;
        chk("deepOe", {padOe, padOut[8]}, {128'h0100, 1'b1});
        chk("deepUp", padPullUp, PULL_UP_MASK & ~128'h0100);
        chk("deepInEn", padInEn & ~pmOverride, '0);
        $display("deep test done");
        conclude();
    end
endmodule // sleep_pin_state_control_tb
